// ==== design/aic_map.svh ====
// Register map, field positions, reset values and timing figures
// Assumes inclusion by bare name from the design files
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH

`define AIC_ADDR_FLAG   8'h2C
`define AIC_ADDR_RSVA   8'h2F
`define AIC_ADDR_IRQA   8'h30
`define AIC_ADDR_IRQB   8'h31
`define AIC_ADDR_RSVB   8'h32
`define AIC_ADDR_PIN    8'h33

`define AIC_CTL_RESET   8'h00
`define AIC_PIN_RESET   8'h00
`define AIC_FLAG_RESET  8'h00
`define AIC_ZERO8       8'h00

`define AIC_EN_HEADSET  7
`define AIC_EN_BUTTON   6
`define AIC_EN_DRC      5
`define AIC_EN_SHORT    3
`define AIC_EN_OVF      2
`define AIC_EN_REPEAT   0

`define AIC_PIN_MODE_HI 5
`define AIC_PIN_MODE_LO 2
`define AIC_PIN_IN      1
`define AIC_PIN_GPO     0

`define AIC_PULSE_US    2000
`define AIC_PERIOD_US   4000
`define AIC_CLK_KHZ     10000
`define AIC_US_PER_MS   1000

`endif

// ==== design/aic_pkg.sv ====
// Types shared by the interrupt and multipurpose pin block
// Assumes nothing beyond a SystemVerilog compiler
package aic_pkg;

    typedef struct packed {
        logic headset;
        logic button;
        logic drcL;
        logic drcR;
        logic shortL;
        logic shortR;
        logic overflow;
    } aic_evt_s;

    typedef enum logic [3:0] {
        PM_OFF   = 4'h0,
        PM_INPUT = 4'h1,
        PM_GPI   = 4'h2,
        PM_GPO   = 4'h3,
        PM_CLK   = 4'h4,
        PM_IRQA  = 4'h5,
        PM_IRQB  = 4'h6,
        PM_BCLK  = 4'h8,
        PM_WCLK  = 4'h9
    } aic_pmode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HIGH = 2'b01,
        ST_LOW  = 2'b10,
        ST_LAST = 2'b11
    } aic_pst_e;

endpackage

// ==== design/aic_irq_pin.sv ====
// Interrupt pulse generators and multipurpose pin multiplexer
// Assumes event inputs and internal clocks are on clk_sys; pin input is async
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_irq_pin #(
    parameter int PULSE_CYC  = `AIC_PULSE_US * `AIC_CLK_KHZ / `AIC_US_PER_MS,
    parameter int PERIOD_CYC = `AIC_PERIOD_US * `AIC_CLK_KHZ / `AIC_US_PER_MS,
    parameter int CNT_W      = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Register port
    input  wire logic             regWr,
    input  wire logic             regRd,
    input  wire logic [7:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    output logic      [7:0]       regRdData,
    output logic                  regRdValid,
    // Event sources
    input  wire aic_pkg::aic_evt_s evt,
    // Internal signals offered to the pin
    input  wire logic             genClk,
    input  wire logic             secBclk,
    input  wire logic             secWclk,
    // Interrupt outputs
    output logic                  irqOutA,
    output logic                  irqOutB,
    // Multipurpose pin
    input  wire logic             pinIn,
    output logic                  pinOut,
    output logic                  pinOe,
    output logic                  pinInEn,
    output logic                  secIn
);

    // ===========================================================
    // Elaboration checks
    if (PULSE_CYC < 1 || PERIOD_CYC <= PULSE_CYC || PERIOD_CYC >= (1 << CNT_W)) begin : g_bad
        $error("aic_irq_pin: pulse timing does not fit the counter");
    end

    localparam logic [CNT_W-1:0] HI_END = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] LO_END = CNT_W'(PERIOD_CYC - PULSE_CYC - 1);

    // ===========================================================
    // Register file
    logic [7:0] ctl [2];
    logic [7:0] next_ctl [2];
    logic [7:0] pinCtl;
    logic [7:0] next_pinCtl;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] next_regRdData;
    logic       flagRead;
    logic [7:0] flagSet;
    logic       pinLvl;
    aic_pkg::aic_pmode_e mode;

    assign flagRead = regRd && (regAddr == `AIC_ADDR_FLAG);
    assign mode     = aic_pkg::aic_pmode_e'(pinCtl[`AIC_PIN_MODE_HI:`AIC_PIN_MODE_LO]);
    assign flagSet  = {evt.shortL, evt.shortR, evt.button, evt.headset,
                       evt.drcL, evt.drcR, 2'h0};

    always_comb begin
        next_ctl[0]    = ctl[0];
        next_ctl[1]    = ctl[1];
        next_pinCtl    = pinCtl;
        // Set wins over the clear of a read in the same cycle
        next_flags     = (flagRead ? `AIC_ZERO8 : flags) | flagSet;
        next_regRdData = regRdData;
        if (regWr) begin
            case (regAddr)
                `AIC_ADDR_IRQA: next_ctl[0] = regWrData;
                `AIC_ADDR_IRQB: next_ctl[1] = regWrData;
                `AIC_ADDR_PIN: begin
                    // Input level bit is never stored
                    next_pinCtl = regWrData;
                    next_pinCtl[`AIC_PIN_IN] = 1'b0;
                end
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                `AIC_ADDR_FLAG: next_regRdData = flags;
                `AIC_ADDR_IRQA: next_regRdData = ctl[0];
                `AIC_ADDR_IRQB: next_regRdData = ctl[1];
                `AIC_ADDR_PIN: begin
                    next_regRdData = pinCtl;
                    next_regRdData[`AIC_PIN_IN] = pinInEn & pinLvl;
                end
                default: next_regRdData = `AIC_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl[0]     <= `AIC_CTL_RESET;
            ctl[1]     <= `AIC_CTL_RESET;
            pinCtl     <= `AIC_PIN_RESET;
            flags      <= `AIC_FLAG_RESET;
            regRdData  <= `AIC_ZERO8;
            regRdValid <= 1'b0;
        end else begin
            ctl[0]     <= next_ctl[0];
            ctl[1]     <= next_ctl[1];
            pinCtl     <= next_pinCtl;
            flags      <= next_flags;
            regRdData  <= next_regRdData;
            regRdValid <= regRd;
        end
    end

    // ===========================================================
    // Interrupt pulse engines, one per output
    aic_pkg::aic_pst_e st [2];
    aic_pkg::aic_pst_e next_st [2];
    logic [CNT_W-1:0]  cnt [2];
    logic [CNT_W-1:0]  next_cnt [2];
    logic [1:0]        trig;
    logic [1:0]        next_irq;

    for (genvar k = 0; k < 2; k++) begin : g_irq
        always_comb begin
            trig[k] = (ctl[k][`AIC_EN_HEADSET] & evt.headset)
                    | (ctl[k][`AIC_EN_BUTTON]  & evt.button)
                    | (ctl[k][`AIC_EN_DRC]     & (evt.drcL | evt.drcR))
                    | (ctl[k][`AIC_EN_SHORT]   & (evt.shortL | evt.shortR))
                    | (ctl[k][`AIC_EN_OVF]     & evt.overflow);
        end

        // Events during a running sequence are absorbed into it
        always_comb begin
            next_st[k]  = st[k];
            next_cnt[k] = cnt[k];
            case (st[k])
                aic_pkg::ST_IDLE: begin
                    if (trig[k]) begin
                        next_st[k]  = aic_pkg::ST_HIGH;
                        next_cnt[k] = '0;
                    end
                end
                aic_pkg::ST_HIGH: begin
                    if (cnt[k] == HI_END) begin
                        next_cnt[k] = '0;
                        if (ctl[k][`AIC_EN_REPEAT] && !flagRead) begin
                            next_st[k] = aic_pkg::ST_LOW;
                        end else begin
                            next_st[k] = aic_pkg::ST_IDLE;
                        end
                    end else begin
                        next_cnt[k] = cnt[k] + 1'b1;
                        if (flagRead) begin
                            next_st[k] = aic_pkg::ST_LAST;
                        end
                    end
                end
                aic_pkg::ST_LAST: begin
                    // Finishes the current pulse at full width, then stops
                    if (cnt[k] == HI_END) begin
                        next_cnt[k] = '0;
                        next_st[k]  = aic_pkg::ST_IDLE;
                    end else begin
                        next_cnt[k] = cnt[k] + 1'b1;
                    end
                end
                aic_pkg::ST_LOW: begin
                    if (flagRead || !ctl[k][`AIC_EN_REPEAT]) begin
                        next_cnt[k] = '0;
                        next_st[k]  = aic_pkg::ST_IDLE;
                    end else if (cnt[k] == LO_END) begin
                        next_cnt[k] = '0;
                        next_st[k]  = aic_pkg::ST_HIGH;
                    end else begin
                        next_cnt[k] = cnt[k] + 1'b1;
                    end
                end
                default: begin
                    next_cnt[k] = '0;
                    next_st[k]  = aic_pkg::ST_IDLE;
                end
            endcase
            next_irq[k] = (next_st[k] == aic_pkg::ST_HIGH) || (next_st[k] == aic_pkg::ST_LAST);
        end

        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                st[k]  <= aic_pkg::ST_IDLE;
                cnt[k] <= '0;
            end else begin
                st[k]  <= next_st[k];
                cnt[k] <= next_cnt[k];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqOutA <= 1'b0;
            irqOutB <= 1'b0;
        end else begin
            irqOutA <= next_irq[0];
            irqOutB <= next_irq[1];
        end
    end

    // ===========================================================
    // Multipurpose pin
    logic [2:0] pinSync;
    logic       next_pinLvl;
    logic       next_pinOut;
    logic       next_pinOe;
    logic       next_pinInEn;
    logic       next_secIn;

    always_comb begin
        // A change counts only once the last two stages agree
        next_pinLvl  = (pinSync[1] == pinSync[2]) ? pinSync[2] : pinLvl;
        next_pinOut  = 1'b0;
        next_pinOe   = 1'b1;
        next_pinInEn = 1'b0;
        case (mode)
            aic_pkg::PM_OFF:   next_pinOe = 1'b0;
            aic_pkg::PM_INPUT: begin
                next_pinOe   = 1'b0;
                next_pinInEn = 1'b1;
            end
            aic_pkg::PM_GPI: begin
                next_pinOe   = 1'b0;
                next_pinInEn = 1'b1;
            end
            aic_pkg::PM_GPO:  next_pinOut = pinCtl[`AIC_PIN_GPO];
            aic_pkg::PM_CLK:  next_pinOut = genClk;
            aic_pkg::PM_IRQA: next_pinOut = next_irq[0];
            aic_pkg::PM_IRQB: next_pinOut = next_irq[1];
            aic_pkg::PM_BCLK: next_pinOut = secBclk;
            aic_pkg::PM_WCLK: next_pinOut = secWclk;
            // Reserved codes behave as powered down
            default:          next_pinOe = 1'b0;
        endcase
        next_secIn = (mode == aic_pkg::PM_INPUT) & next_pinLvl;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinSync <= 3'h0;
            pinLvl  <= 1'b0;
            pinOut  <= 1'b0;
            pinOe   <= 1'b0;
            pinInEn <= 1'b0;
            secIn   <= 1'b0;
        end else begin
            pinSync <= {pinSync[1:0], pinIn};
            pinLvl  <= next_pinLvl;
            pinOut  <= next_pinOut;
            pinOe   <= next_pinOe;
            pinInEn <= next_pinInEn;
            secIn   <= next_secIn;
        end
    end

    // ===========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_pulse_width: assert property ($fell(irqOutA) |-> $past(cnt[0]) == HI_END)
        else $error("first interrupt pulse width wrong");
    chk_single_stop: assert property ($fell(irqOutA) && !$past(ctl[0][`AIC_EN_REPEAT])
                                      |-> st[0] == aic_pkg::ST_IDLE)
        else $error("single pulse mode repeated");
    chk_repeat_gap: assert property ($rose(irqOutB) && $past(st[1]) == aic_pkg::ST_LOW
                                     |-> $past(cnt[1]) == LO_END)
        else $error("repeat gap length wrong");
    // A fresh enabled event right after the stop may legally start a new sequence
    chk_read_stops: assert property (st[1] == aic_pkg::ST_LOW && flagRead
                                     |=> !irqOutB ##1 (!irqOutB || $past(trig[1])))
        else $error("flag read did not stop repeats");
    chk_src_start: assert property (st[0] == aic_pkg::ST_IDLE && trig[0] |=> irqOutA)
        else $error("enabled source gave no pulse");
    chk_src_mask: assert property (st[1] == aic_pkg::ST_IDLE && !trig[1] |=> !irqOutB)
        else $error("disabled source gave a pulse");
    chk_flag_clear: assert property (flagRead && flagSet == `AIC_ZERO8 |=> flags == `AIC_ZERO8)
        else $error("flags not cleared by read");
    chk_flag_set: assert property (evt.headset |=> flags[4])
        else $error("headset flag not set");
    chk_pin_off: assert property (mode == aic_pkg::PM_OFF |=> !pinOe && !pinInEn)
        else $error("pin buffers not powered down");
    chk_pin_gpo: assert property (mode == aic_pkg::PM_GPO |=> pinOe && pinOut == $past(pinCtl[`AIC_PIN_GPO]))
        else $error("general output level wrong");
    chk_pin_irq: assert property (mode == aic_pkg::PM_IRQA |-> pinOut == irqOutA || $changed(mode))
        else $error("pin does not follow first interrupt");
    chk_pin_read: assert property (regRd && regAddr == `AIC_ADDR_PIN
                                   |=> regRdData[`AIC_PIN_IN] == $past(pinInEn & pinLvl))
        else $error("pin level read wrong");

    cov_single: cover property ($fell(irqOutA) && st[0] == aic_pkg::ST_IDLE);
    cov_repeat: cover property ($rose(irqOutB) && $past(st[1]) == aic_pkg::ST_LOW);
    cov_read_set: cover property (flagRead && flagSet != `AIC_ZERO8);
    cov_gpi: cover property (mode == aic_pkg::PM_GPI && pinLvl);

endmodule

// ==== tb/aic_host_model.sv ====
// Host model: issues register writes and reads on the parallel strobe port
// Assumes clk_sys from the bench; requests launch on falling edges
`timescale 1ns/1ps
module aic_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic            regWr,
    output logic            regRd,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regWr     = 1'b0;
        regRd     = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // ========================================
    // Bus cycles
    // Released address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == 8'h33) ? {2'b00, d[5:0]} : d;
        @(negedge clk_sys);
        regAddr   = a;
        regWrData = v;
        regWr     = 1'b1;
        @(negedge clk_sys);
        regWr     = 1'b0;
        regAddr   = ~a;
        regWrData = ~v;
    endtask

    // Answer stands in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        regAddr = a;
        regRd   = 1'b1;
        @(negedge clk_sys);
        regRd   = 1'b0;
        regAddr = ~a;
        d       = regRdData;
        ok      = regRdValid;
    endtask
endmodule

// ==== tb/audio_irq_and_multipin_control_test.sv ====
// Self-checking bench for the interrupt and multipurpose pin block
// Assumes the host model drives the register port; pulse counts shortened
`timescale 1ns/1ps
module audio_irq_and_multipin_control_test;
    localparam int PULSE  = 4;
    localparam int PERIOD = 10;

    logic              clk_sys = 1'b0;
    logic              resetn  = 1'b0;
    logic              regWr;
    logic              regRd;
    logic [7:0]        regAddr;
    logic [7:0]        regWrData;
    logic [7:0]        regRdData;
    logic              regRdValid;
    aic_pkg::aic_evt_s evt     = '0;
    logic              genClk  = 1'b0;
    logic              secBclk = 1'b0;
    logic              secWclk = 1'b0;
    logic              extLvl  = 1'b0;
    logic              irqOutA;
    logic              irqOutB;
    logic              pinWire;
    logic              pinOut;
    logic              pinOe;
    logic              pinInEn;
    logic              secIn;
    int                failures = 0;
    int                cmp_count = 0;
    int                pinHi = 0;
    logic [7:0]        enBit [7] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h08, 8'h08, 8'h04};
    logic [7:0]        allAddr [7] = '{8'h2C, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40};
    logic [7:0]        rsvAddr [3] = '{8'h2F, 8'h32, 8'h40};

    always #50 clk_sys = ~clk_sys;

    // Pin level: our driver when enabled, else the outside level
    assign pinWire = pinOe ? pinOut : extLvl;

    aic_host_model host (.clk_sys(clk_sys), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

    aic_irq_pin #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD), .CNT_W(16)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .evt(evt),
        .genClk(genClk), .secBclk(secBclk), .secWclk(secWclk), .irqOutA(irqOutA), .irqOutB(irqOutB),
        .pinIn(pinWire), .pinOut(pinOut), .pinOe(pinOe), .pinInEn(pinInEn), .secIn(secIn));

    // ========================================
    // Helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    // Counts high cycles of both outputs and the pin; also ends any event pulse
    task automatic count_hi(input int n, output int ca, output int cb);
        ca = 0;
        cb = 0;
        repeat (n) begin
            @(negedge clk_sys);
            evt = '0;
            ca += int'(irqOutA === 1'b1);
            cb += int'(irqOutB === 1'b1);
            pinHi += int'(pinOut === 1'b1);
        end
    endtask

    task automatic fire(input logic [7:0] ctlA, input logic [7:0] ctlB, input logic [6:0] e,
                        input int win, input int expA, input int expB);
        int ca;
        int cb;
        host.wr(8'h30, ctlA);
        host.wr(8'h31, ctlB);
        @(negedge clk_sys);
        evt = aic_pkg::aic_evt_s'(e);
        count_hi(win, ca, cb);
        check(8'(ca), 8'(expA));
        check(8'(cb), 8'(expB));
    endtask

    task automatic pin_check(input logic [3:0] m, input logic p);
        logic oe;
        logic ie;
        logic o;
        oe = m inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
        ie = m inside {4'h1, 4'h2};
        case (m)
            4'h3: o = p;
            4'h4: o = genClk;
            4'h8: o = secBclk;
            4'h9: o = secWclk;
            default: o = 1'b0;
        endcase
        check({6'h00, pinOe, pinInEn}, {6'h00, oe, ie});
        if (oe) check({7'h00, pinOut}, {7'h00, o});
        check({7'h00, secIn}, {7'h00, (m == 4'h1) && extLvl});
        chk_rd(8'h33, {2'b00, m, ie & extLvl, p});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================
    // Tests
    initial begin
        int ca;
        int cb;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        foreach (allAddr[i]) chk_rd(allAddr[i], 8'h00);
        foreach (rsvAddr[i]) begin
            host.wr(rsvAddr[i], 8'hFF);
            chk_rd(rsvAddr[i], 8'h00);
        end
        host.wr(8'h30, 8'h5A);
        chk_rd(8'h30, 8'h5A);
        host.wr(8'h31, 8'hA5);
        chk_rd(8'h31, 8'hA5);
        $display("test registers done");

        // Each source alone, enabled on one output and masked on the other
        for (int i = 0; i < 7; i++) begin
            fire(enBit[i], ~enBit[i] & 8'hEC, 7'h40 >> i, 14, PULSE, 0);
            fire(~enBit[i] & 8'hEC, enBit[i], 7'h40 >> i, 14, 0, PULSE);
        end
        chk_rd(8'h2C, 8'hFC);
        chk_rd(8'h2C, 8'h00);
        $display("test sources done");

        // Repeat mode on one output, single pulse on the other, stopped by a flag read
        for (int k = 0; k < 2; k++) begin
            // Window ends so that the flag read lands in the low gap
            fire(k == 0 ? 8'h41 : 8'h40, k == 0 ? 8'h40 : 8'h41, 7'h20, 28,
                 k == 0 ? 3 * PULSE : PULSE, k == 0 ? PULSE : 3 * PULSE);
            chk_rd(8'h2C, 8'h20);
            count_hi(12, ca, cb);
            count_hi(30, ca, cb);
            check(8'(ca + cb), 8'h00);
        end
        // Read while high: the pulse runs to full width, then no more follow
        fire(8'h41, 8'h00, 7'h20, 2, 2, 0);
        chk_rd(8'h2C, 8'h20);
        check({7'h00, irqOutA}, 8'h01);
        count_hi(20, ca, cb);
        check(8'(ca + cb), 8'h00);
        $display("test repeat done");

        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 16; m++) begin
                // Only the selected source differs from the rest, so a wrong route shows
                genClk  = p[0] ^ (m == 4);
                secBclk = p[0] ^ (m == 8);
                secWclk = p[0] ^ (m == 9);
                extLvl  = ~p[0];
                host.wr(8'h33, {2'b00, m[3:0], 1'b0, p[0] ^ (m == 3)});
                repeat (6) @(negedge clk_sys);
                pin_check(m[3:0], p[0] ^ (m == 3));
            end
        end
        // Interrupt routed to the pin: the pin carries exactly that output's pulse
        for (int k = 0; k < 2; k++) begin
            host.wr(8'h33, k == 0 ? 8'h14 : 8'h18);
            pinHi = 0;
            fire(k == 0 ? 8'h40 : 8'h00, k == 0 ? 8'h00 : 8'h40, 7'h20, 14,
                 k == 0 ? PULSE : 0, k == 0 ? 0 : PULSE);
            check(8'(pinHi), 8'(PULSE));
        end
        if (1) begin
            if (1) begin
            end
        end
        $display("test pin modes done");
        wrap_up();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #5000000;
        failures++;
        wrap_up();
    end
endmodule
